// file: src/compressor_pkg.sv
package compressor_pkg;

    // Sample and queue word geometry.
    localparam int AXIS_W   = 16;
    localparam int SAMPLE_W = 48;
    localparam int TAG_W    = 5;
    localparam int DIFF_W   = 17;
    localparam int NUM_CHAN = 2;
    localparam int LIST_LEN = 8;
    localparam int LIST_W   = 4;

    // One queue word: a tag and six data bytes, X low byte in bits 7:0.
    typedef struct packed {
        logic [TAG_W-1:0]    tag;
        logic [SAMPLE_W-1:0] data;
    } qword_t;

    // Compression level last chosen by a channel.
    typedef enum logic [1:0] {
        LVL_NONE   = 2'h0,
        LVL_NC     = 2'h1,
        LVL_PAIR   = 2'h2,
        LVL_TRIPLE = 2'h3
    } level_t;

    // Window fill states, Gray coded along first, empty, one, two.
    typedef enum logic [1:0] {
        WIN_FIRST = 2'h0,
        WIN_EMPTY = 2'h1,
        WIN_ONE   = 2'h3,
        WIN_TWO   = 2'h2
    } win_t;

    // Tag kinds, added to the base tag of each sensor.
    localparam logic [TAG_W-1:0] KIND_NC     = 5'h00;
    localparam logic [TAG_W-1:0] KIND_NC_T1  = 5'h01;
    localparam logic [TAG_W-1:0] KIND_NC_T2  = 5'h02;
    localparam logic [TAG_W-1:0] KIND_PAIR   = 5'h03;
    localparam logic [TAG_W-1:0] KIND_TRIPLE = 5'h04;
    localparam logic [TAG_W-1:0] ACC_TAG_BASE = 5'h01;
    localparam logic [TAG_W-1:0] GYR_TAG_BASE = 5'h08;
    localparam logic [TAG_W-1:0] CFG_TAG      = 5'h10;
    localparam logic [TAG_W-1:0] TS_TAG       = 5'h11;

    // Slope thresholds in LSB.
    localparam logic [DIFF_W-1:0] TRIPLE_LIMIT = 17'h00010;
    localparam logic [DIFF_W-1:0] PAIR_LIMIT   = 17'h00080;

    // Register byte offsets and bit positions.
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_INIT   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_WORDS  = 4'hc;
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_RT_BIT     = 1;
    localparam int INIT_REINIT_BIT = 0;
    localparam int INIT_CFG_BIT    = 1;
    localparam int ST_ACC_LVL_LSB  = 0;
    localparam int ST_GYR_LVL_LSB  = 2;
    localparam int ST_BUSY_BIT     = 4;
    localparam int ST_DROP_BIT     = 5;
    localparam int ST_MARK_BIT     = 6;
    localparam int ST_ACTIVE_BIT   = 7;

endpackage

// file: src/chan_if.sv
interface chan_if;
    import compressor_pkg::*;

    logic                ev;
    logic                flush;
    logic                active;
    logic                reinit;
    logic [SAMPLE_W-1:0] sample;
    logic [1:0]          nwords;
    qword_t [2:0]        words;
    level_t              level;

    modport ctrl (output ev, flush, active, reinit, sample, input nwords, words, level);
    modport chan (input ev, flush, active, reinit, sample, output nwords, words, level);
endinterface

// file: src/delta_channel.sv
module delta_channel
    import compressor_pkg::*;
#(
    parameter logic [TAG_W-1:0] TAG_BASE = ACC_TAG_BASE
) (
    input wire logic clk,
    input wire logic reset_n,
    chan_if.chan     ch
);

    win_t                state_ff;
    logic [SAMPLE_W-1:0] ref_ff;
    logic [SAMPLE_W-1:0] old_ff;
    logic [SAMPLE_W-1:0] new_ff;
    level_t              lvl_ff;
    logic [DIFF_W-1:0]   d2 [3];
    logic [DIFF_W-1:0]   d1 [3];
    logic [DIFF_W-1:0]   d0 [3];
    logic [DIFF_W-1:0]   a2 [3];
    logic [DIFF_W-1:0]   a1 [3];
    logic [DIFF_W-1:0]   a0 [3];
    logic [DIFF_W-1:0]   max_pair;
    logic [DIFF_W-1:0]   max_all;
    logic [SAMPLE_W-1:0] pair_data;
    logic [SAMPLE_W-1:0] triple_data;

    // Per-axis differences across the window, sign extended so they cannot wrap.
    genvar a;
    generate
        for (a = 0; a < 3; a++) begin : g_axis
            assign d2[a] = {old_ff[AXIS_W*a+AXIS_W-1], old_ff[AXIS_W*a +: AXIS_W]}
                         - {ref_ff[AXIS_W*a+AXIS_W-1], ref_ff[AXIS_W*a +: AXIS_W]};
            assign d1[a] = {new_ff[AXIS_W*a+AXIS_W-1], new_ff[AXIS_W*a +: AXIS_W]}
                         - {old_ff[AXIS_W*a+AXIS_W-1], old_ff[AXIS_W*a +: AXIS_W]};
            assign d0[a] = {ch.sample[AXIS_W*a+AXIS_W-1], ch.sample[AXIS_W*a +: AXIS_W]}
                         - {new_ff[AXIS_W*a+AXIS_W-1], new_ff[AXIS_W*a +: AXIS_W]};
            assign a2[a] = d2[a][DIFF_W-1] ? DIFF_W'(-d2[a]) : d2[a];
            assign a1[a] = d1[a][DIFF_W-1] ? DIFF_W'(-d1[a]) : d1[a];
            assign a0[a] = d0[a][DIFF_W-1] ? DIFF_W'(-d0[a]) : d0[a];
        end
    endgenerate

    // Largest slope over all axes decides the level for the whole window.
    always_comb begin
        max_pair = '0;
        max_all  = '0;
        for (int i = 0; i < 3; i++) begin
            if (a2[i] > max_pair) max_pair = a2[i];
            if (a1[i] > max_pair) max_pair = a1[i];
            if (a0[i] > max_all)  max_all  = a0[i];
        end
        if (max_pair > max_all) max_all = max_pair;
    end

    // Packed payloads: bytes X_L..Z_H for pairs, 5-bit fields for triples.
    assign pair_data   = {d1[2][7:0], d1[1][7:0], d1[0][7:0],
                          d2[2][7:0], d2[1][7:0], d2[0][7:0]};
    assign triple_data = {1'b0, d0[2][4:0], d0[1][4:0], d0[0][4:0],
                          1'b0, d1[2][4:0], d1[1][4:0], d1[0][4:0],
                          1'b0, d2[2][4:0], d2[1][4:0], d2[0][4:0]};

    // Words this event would emit, in queue order.
    always_comb begin
        ch.nwords = 2'h0;
        ch.words  = '0;
        if (ch.flush) begin
            if (state_ff == WIN_TWO) begin
                ch.words[0] = '{tag: TAG_BASE + KIND_NC_T2, data: old_ff};
                ch.words[1] = '{tag: TAG_BASE + KIND_NC_T1, data: new_ff};
                ch.words[2] = '{tag: TAG_BASE + KIND_NC,    data: ch.sample};
                ch.nwords   = 2'h3;
            end else if (state_ff == WIN_ONE) begin
                ch.words[0] = '{tag: TAG_BASE + KIND_NC_T1, data: new_ff};
                ch.words[1] = '{tag: TAG_BASE + KIND_NC,    data: ch.sample};
                ch.nwords   = 2'h2;
            end else begin
                ch.words[0] = '{tag: TAG_BASE + KIND_NC, data: ch.sample};
                ch.nwords   = 2'h1;
            end
        end else if (!ch.active || state_ff == WIN_FIRST) begin
            ch.words[0] = '{tag: TAG_BASE + KIND_NC, data: ch.sample};
            ch.nwords   = 2'h1;
        end else if (state_ff == WIN_TWO) begin
            if (max_all < TRIPLE_LIMIT) begin
                ch.words[0] = '{tag: TAG_BASE + KIND_TRIPLE, data: triple_data};
            end else if (max_pair <= PAIR_LIMIT) begin
                ch.words[0] = '{tag: TAG_BASE + KIND_PAIR, data: pair_data};
            end else begin
                ch.words[0] = '{tag: TAG_BASE + KIND_NC_T2, data: old_ff};
            end
            ch.nwords = 2'h1;
        end
    end

    // Window state: the two oldest unwritten samples wait, delaying output two periods.
    always_ff @(posedge clk) begin
        if (!reset_n || ch.reinit) begin
            state_ff <= WIN_FIRST;
            ref_ff   <= '0;
            old_ff   <= '0;
            new_ff   <= '0;
        end else if (ch.ev) begin
            if (ch.flush || !ch.active || state_ff == WIN_FIRST) begin
                ref_ff   <= ch.sample;
                state_ff <= ch.active ? WIN_EMPTY : WIN_FIRST;
            end else if (state_ff == WIN_EMPTY) begin
                old_ff   <= ch.sample;
                state_ff <= WIN_ONE;
            end else if (state_ff == WIN_ONE) begin
                new_ff   <= ch.sample;
                state_ff <= WIN_TWO;
            end else if (max_all < TRIPLE_LIMIT) begin
                ref_ff   <= ch.sample;
                state_ff <= WIN_EMPTY;
            end else if (max_pair <= PAIR_LIMIT) begin
                ref_ff   <= new_ff;
                old_ff   <= ch.sample;
                state_ff <= WIN_ONE;
            end else begin
                ref_ff   <= old_ff;
                old_ff   <= new_ff;
                new_ff   <= ch.sample;
            end
        end
    end

    // Level of the last word this channel chose, for status.
    always_ff @(posedge clk) begin
        if (!reset_n || ch.reinit) begin
            lvl_ff <= LVL_NONE;
        end else if (ch.ev && ch.nwords != 2'h0) begin
            if (ch.words[0].tag == TAG_BASE + KIND_TRIPLE) lvl_ff <= LVL_TRIPLE;
            else if (ch.words[0].tag == TAG_BASE + KIND_PAIR) lvl_ff <= LVL_PAIR;
            else lvl_ff <= LVL_NC;
        end
    end
    assign ch.level = lvl_ff;

endmodule // delta_channel

// file: src/fifo_delta_compressor.sv
// How it works
// - Both sensors compressed, levels chosen independently.
// - Slope above 128 LSB: one uncompressed sample.
// - Slope 16 to 128 LSB: two deltas per word.
// - Five tags per sensor: current, previous, two-back, pair, triple.
// - First event after start writes uncompressed current.
// - Later entries: triple, pair or two-back sample.
// - Previous-slot words only appear when flushing.
// - Three-period window delays data two periods.
// - Pair word carries six signed bytes, oldest first.
// - Triple word packs three 5-bit deltas per axis.
// - Runtime enable change acts as configuration change while master enable is set.
// - Pending samples flushed in one slot; with one pending, the previous word carries new_ff, not the pending sample.
// - Flush order: marker, timestamp, two-back, previous, current.
// - Disabled compression writes current sample each event.
// - After flush, compression restarts with fresh window.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
module fifo_delta_compressor
    import compressor_pkg::*;
(
    // Clock and reset.
    input  wire logic                CLK,
    input  wire logic                RESET_N,
    // Avalon-MM register slave.
    input  wire logic [3:0]          AVS_ADDRESS,
    input  wire logic                AVS_READ,
    input  wire logic                AVS_WRITE,
    input  wire logic [31:0]         AVS_WRITEDATA,
    input  wire logic [3:0]          AVS_BYTEENABLE,
    output logic      [31:0]         AVS_READDATA,
    output logic                     AVS_WAITREQUEST,
    // Sensor streams and batch events.
    input  wire logic                BATCH_EVENT,
    input  wire logic                ACC_VALID,
    input  wire logic [SAMPLE_W-1:0] ACC_SAMPLE,
    input  wire logic                GYR_VALID,
    input  wire logic [SAMPLE_W-1:0] GYR_SAMPLE,
    input  wire logic [31:0]         TIMESTAMP,
    input  wire logic                CONFIG_CHANGE,
    // Queue write port.
    output logic                     QUEUE_WR,
    output logic      [TAG_W-1:0]    QUEUE_TAG,
    output logic      [SAMPLE_W-1:0] QUEUE_DATA
);

    // Register bus state.
    logic                waitreq_ff;
    logic [31:0]         rdata_ff;
    logic [31:0]         nxt_rdata;
    logic                bus_req;
    logic                wr_take;

    // Software controls and sticky status.
    logic                master_en_ff;
    logic                rt_en_ff;
    logic                reinit_ff;
    logic                sw_cfg_ff;
    logic                active_prev_ff;
    logic                drop_ff;
    logic                marker_ff;
    logic [NUM_CHAN-1:0] flush_ff;
    logic [31:0]         words_ff;
    logic                active;
    logic                change;

    // Emission list and queue output registers.
    qword_t              list_ff [LIST_LEN];
    qword_t              nxt_list [LIST_LEN];
    logic [LIST_W-1:0]   len_ff;
    logic [LIST_W-1:0]   nxt_len;
    logic [LIST_W-1:0]   idx_ff;
    logic                busy;
    logic                accept;
    logic                q_wr_ff;
    logic [TAG_W-1:0]    q_tag_ff;
    logic [SAMPLE_W-1:0] q_data_ff;

    // Per-channel views of the encoders.
    logic [NUM_CHAN-1:0] ch_valid;
    logic [SAMPLE_W-1:0] ch_sample [NUM_CHAN];
    logic [1:0]          ch_nwords [NUM_CHAN];
    qword_t [2:0]        ch_words  [NUM_CHAN];
    level_t              ch_level  [NUM_CHAN];

    chan_if chans [NUM_CHAN] ();

    assign bus_req = AVS_READ || AVS_WRITE;
    assign wr_take = AVS_WRITE && !waitreq_ff && AVS_BYTEENABLE[0];

    // Compression runs only when both enables are set.
    assign active = master_en_ff && rt_en_ff;
    assign change = (active != active_prev_ff) || CONFIG_CHANGE || sw_cfg_ff;

    // Events that land while a previous slot is still draining are dropped.
    assign busy   = idx_ff != len_ff;
    assign accept = BATCH_EVENT && !busy;

    assign ch_valid     = {GYR_VALID, ACC_VALID};
    assign ch_sample[0] = ACC_SAMPLE;
    assign ch_sample[1] = GYR_SAMPLE;

    // One encoder per sensor, each with its own level decision.
    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            assign chans[c].ev     = accept && ch_valid[c];
            assign chans[c].flush  = flush_ff[c];
            assign chans[c].active = active;
            assign chans[c].reinit = reinit_ff;
            assign chans[c].sample = ch_sample[c];
            assign ch_nwords[c]    = chans[c].nwords;
            assign ch_words[c]     = chans[c].words;
            assign ch_level[c]     = chans[c].level;

            delta_channel #(
                .TAG_BASE (c == 0 ? ACC_TAG_BASE : GYR_TAG_BASE)
            ) u_chan (
                .clk     (CLK),
                .reset_n (RESET_N),
                .ch      (chans[c])
            );
        end
    endgenerate

    // Waitrequest drops for one cycle after a request appears, then rises again.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            waitreq_ff <= 1'b1;
        end else if (bus_req && waitreq_ff) begin
            waitreq_ff <= 1'b0;
        end else begin
            waitreq_ff <= 1'b1;
        end
    end

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        nxt_rdata = '0;
        if (AVS_ADDRESS == REG_CTRL) begin
            nxt_rdata[CTRL_MASTER_BIT] = master_en_ff;
            nxt_rdata[CTRL_RT_BIT]     = rt_en_ff;
        end else if (AVS_ADDRESS == REG_STATUS) begin
            nxt_rdata[ST_ACC_LVL_LSB +: 2] = ch_level[0];
            nxt_rdata[ST_GYR_LVL_LSB +: 2] = ch_level[1];
            nxt_rdata[ST_BUSY_BIT]         = busy;
            nxt_rdata[ST_DROP_BIT]         = drop_ff;
            nxt_rdata[ST_MARK_BIT]         = marker_ff;
            nxt_rdata[ST_ACTIVE_BIT]       = active;
        end else if (AVS_ADDRESS == REG_WORDS) begin
            nxt_rdata = words_ff;
        end else begin
            nxt_rdata = '0;
        end
    end

    // Read data is loaded while waitrequest is still high, so it stands at the sampling edge.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rdata_ff <= '0;
        end else if (AVS_READ && waitreq_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Enable bits; a write takes effect only on the completing edge.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            master_en_ff <= 1'b0;
            rt_en_ff     <= 1'b0;
        end else if (wr_take && AVS_ADDRESS == REG_CTRL) begin
            master_en_ff <= AVS_WRITEDATA[CTRL_MASTER_BIT];
            rt_en_ff     <= AVS_WRITEDATA[CTRL_RT_BIT];
        end
    end

    // Reinit and software configuration change are one-cycle strobes from writes.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            reinit_ff <= 1'b0;
            sw_cfg_ff <= 1'b0;
        end else begin
            reinit_ff <= wr_take && AVS_ADDRESS == REG_INIT
                         && AVS_WRITEDATA[INIT_REINIT_BIT];
            sw_cfg_ff <= wr_take && AVS_ADDRESS == REG_INIT
                         && AVS_WRITEDATA[INIT_CFG_BIT];
        end
    end

    // Track the enable so any change of it is seen as a configuration change.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            active_prev_ff <= 1'b0;
        end else begin
            active_prev_ff <= active;
        end
    end

    // Marker pending until the next batch event; a new change beats the clear.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            marker_ff <= 1'b0;
        end else if (change) begin
            marker_ff <= 1'b1;
        end else if (accept || reinit_ff) begin
            marker_ff <= 1'b0;
        end
    end

    // Each sensor flushes its pending window at its own next sample after a change.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            flush_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (change) begin
                    flush_ff[i] <= 1'b1;
                end else if ((accept && ch_valid[i]) || reinit_ff) begin
                    flush_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Sticky drop flag, cleared by writing one; a new drop wins over the clear.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            drop_ff <= 1'b0;
        end else if (BATCH_EVENT && busy) begin
            drop_ff <= 1'b1;
        end else if (wr_take && AVS_ADDRESS == REG_STATUS && AVS_WRITEDATA[ST_DROP_BIT]) begin
            drop_ff <= 1'b0;
        end
    end

    // Build the slot: marker and timestamp first, then accelerometer, then gyroscope.
    always_comb begin
        logic [LIST_W-1:0] n;
        n        = '0;
        nxt_list = list_ff;
        nxt_len  = len_ff;
        if (accept) begin
            if (marker_ff) begin
                nxt_list[0] = '{tag: CFG_TAG, data: SAMPLE_W'({rt_en_ff, master_en_ff})};
                nxt_list[1] = '{tag: TS_TAG,  data: SAMPLE_W'(TIMESTAMP)};
                n = LIST_W'(2);
            end
            for (int i = 0; i < NUM_CHAN; i++) begin
                for (int k = 0; k < 3; k++) begin
                    if (ch_valid[i] && k < int'(ch_nwords[i])) begin
                        nxt_list[n[2:0]] = ch_words[i][k];
                        n = n + LIST_W'(1);
                    end
                end
            end
            nxt_len = n;
        end
    end

    // Emission list storage; rewritten only when a new slot is accepted.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < LIST_LEN; i++) begin
                list_ff[i] <= '0;
            end
        end else if (accept) begin
            list_ff <= nxt_list;
        end
    end

    // Length and read index of the slot being drained.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            len_ff <= '0;
            idx_ff <= '0;
        end else if (accept) begin
            len_ff <= nxt_len;
            idx_ff <= '0;
        end else if (busy) begin
            idx_ff <= idx_ff + LIST_W'(1);
        end
    end

    // One queue word per cycle while a slot drains; all words share the slot.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            q_wr_ff   <= 1'b0;
            q_tag_ff  <= '0;
            q_data_ff <= '0;
        end else if (busy) begin
            q_wr_ff   <= 1'b1;
            q_tag_ff  <= list_ff[idx_ff[2:0]].tag;
            q_data_ff <= list_ff[idx_ff[2:0]].data;
        end else begin
            q_wr_ff   <= 1'b0;
        end
    end

    // Count of words written to the queue, wrapping.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            words_ff <= '0;
        end else if (q_wr_ff) begin
            words_ff <= words_ff + 32'h1;
        end
    end

    assign AVS_READDATA    = rdata_ff;
    assign AVS_WAITREQUEST = waitreq_ff;
    assign QUEUE_WR        = q_wr_ff;
    assign QUEUE_TAG       = q_tag_ff;
    assign QUEUE_DATA      = q_data_ff;

endmodule // fifo_delta_compressor

// file: test/fdc_monitor.sv
module fdc_monitor
    import compressor_pkg::*;
(
    // Clock, reset and bus handshake.
    input wire logic                CLK,
    input wire logic                RESET_N,
    input wire logic                AVS_READ,
    input wire logic                AVS_WRITE,
    input wire logic                AVS_WAITREQUEST,
    // Batch input and queue port.
    input wire logic                BATCH_EVENT,
    input wire logic                QUEUE_WR,
    input wire logic [TAG_W-1:0]    QUEUE_TAG,
    input wire logic [SAMPLE_W-1:0] QUEUE_DATA
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // Each request is answered exactly once.
    chk_wait_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest held low");
    chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("request not answered");
    chk_wait_idle: assert property (!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
        else $error("answer without request");
    // A word starts two edges after an event or continues a slot.
    chk_word_cause: assert property (QUEUE_WR |-> $past(BATCH_EVENT, 2) || $past(QUEUE_WR))
        else $error("queue word without cause");
    chk_slot_max: assert property (QUEUE_WR [*8] |=> !QUEUE_WR)
        else $error("slot longer than eight words");
    chk_tag_legal: assert property (QUEUE_WR |-> QUEUE_TAG inside
        {[5'h01:5'h05], [5'h08:5'h0c], 5'h10, 5'h11}) else $error("illegal tag");
    chk_word_hold: assert property (!QUEUE_WR |-> $stable(QUEUE_TAG) && $stable(QUEUE_DATA))
        else $error("queue word not held");
    chk_cfg_then_ts: assert property (QUEUE_WR && QUEUE_TAG == CFG_TAG
        |=> QUEUE_WR && QUEUE_TAG == TS_TAG) else $error("marker not followed by timestamp");
endmodule // fdc_monitor

bind fifo_delta_compressor fdc_monitor i_fdc_monitor (.*);

// file: test/host_model.sv
module host_model
    import compressor_pkg::*;
(
    // Queue write port as the host sees it.
    input wire logic                CLK,
    input wire logic                QUEUE_WR,
    input wire logic [TAG_W-1:0]    QUEUE_TAG,
    input wire logic [SAMPLE_W-1:0] QUEUE_DATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [52:0] q [$];
    logic [47:0] last;

    // Words queue in order; only accel words are decoded.
    always @(posedge CLK) begin : decode
        logic        [4:0] k;
        logic signed [7:0] b;
        logic signed [4:0] f;
        k = QUEUE_TAG - ACC_TAG_BASE;
        if (QUEUE_WR) q.push_back({QUEUE_TAG, QUEUE_DATA});
        for (int j = 0; j < 9; j++) begin
            b = QUEUE_DATA[8*(j%6)+:8];
            f = QUEUE_DATA[16*(j/3)+5*(j%3)+:5];
            if (!QUEUE_WR || QUEUE_TAG >= GYR_TAG_BASE) break;
            if (k < KIND_PAIR && j < 3) last[16*j+:16] = QUEUE_DATA[16*j+:16];
            else if (k == KIND_PAIR && j < 6) last[16*(j%3)+:16] += 16'(b);
            else if (k == KIND_TRIPLE) last[16*(j%3)+:16] += 16'(f);
        end
    end
endmodule // host_model

// file: test/tb.sv
module tb
    import compressor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              CLK, RESET_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, BATCH_EVENT;
    logic              ACC_VALID, CONFIG_CHANGE, QUEUE_WR;
    logic [3:0]        AVS_ADDRESS;
    logic [31:0]       AVS_WRITEDATA, AVS_READDATA, TIMESTAMP, ts, rd;
    logic [TAG_W-1:0]  QUEUE_TAG;
    logic [47:0]       ACC_SAMPLE, QUEUE_DATA;
    logic [47:0]       s [0:11];
    int                n_errors, n_tests;

    fifo_delta_compressor i_fifo_delta_compressor (.AVS_BYTEENABLE(4'hf), .GYR_VALID(1'b0),
        .GYR_SAMPLE(48'h0), .*);
    host_model i_host_model (.*);

    // Free-running 125 MHz clock.
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    task test_done();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [52:0] seen, input logic [52:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Pops the oldest word; an empty queue mismatches.
    task expw(input logic [4:0] t, input logic [47:0] d);
        logic [52:0] w;
        w = 'x;
        if (i_host_model.q.size() != 0) w = i_host_model.q.pop_front();
        chk(w, {t, d}, "queue word");
    endtask

    // Avalon-MM transfer held until waitrequest is sampled low.
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    // Next sample: each axis moves by lo plus up to span LSB, random sign.
    task nxt(input int k, input int lo, input int span);
        int d;
        for (int a = 0; a < 3; a++) begin
            d = lo + $urandom_range(span);
            if ($urandom_range(1) != 0) d = -d;
            s[k][16*a+:16] = s[k-1][16*a+:16] + 16'(d);
        end
    endtask

    // Optional config pulse, then one batch event and a drain wait.
    task ev(input int k, input logic cc);
        @(posedge CLK);
        CONFIG_CHANGE <= cc;
        @(posedge CLK);
        CONFIG_CHANGE <= 1'b0;
        @(posedge CLK);
        ts = $urandom;
        {BATCH_EVENT, ACC_VALID, ACC_SAMPLE, TIMESTAMP} <= {2'b11, s[k], ts};
        @(posedge CLK);
        {BATCH_EVENT, ACC_VALID} <= 2'b00;
        repeat (12) @(posedge CLK);
    endtask

    // Pair packs bytes of i-2 then i-1; triple packs 5-bit fields of i-2, i-1, i.
    function automatic logic [47:0] enc(int k, bit t3);
        logic [47:0] w;
        logic [15:0] d;
        w = '0;
        for (int j = 0; j < 9; j++) begin
            d = s[k-2+j/3][16*(j%3)+:16] - s[k-3+j/3][16*(j%3)+:16];
            if (t3) w[16*(j/3)+5*(j%3)+:5] = d[4:0];
            else if (j < 6) w[8*j+:8] = d[7:0];
        end
        return w;
    endfunction

    // Hang guard, far above the run length.
    initial begin
        repeat (6000) @(posedge CLK);
        n_errors++;
        test_done();
    end

    initial begin
        {RESET_N, AVS_READ, AVS_WRITE, BATCH_EVENT, ACC_VALID, CONFIG_CHANGE} = '0;
        {AVS_ADDRESS, AVS_WRITEDATA, ACC_SAMPLE, TIMESTAMP} = '0;
        void'($urandom(50473));
        repeat (5) @(posedge CLK);
        RESET_N <= 1'b1;
        for (int a = 0; a < 3; a++) s[0][16*a+:16] = 16'($urandom_range(8000));
        bus(1'b1, REG_CTRL, 32'h3);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(53'(rd), 53'h3, "control");
        ev(0, 1'b0);
        expw(CFG_TAG, 48'h3);
        expw(TS_TAG, 48'(ts));
        expw(ACC_TAG_BASE + KIND_NC, s[0]);
        $display("test enable done");
        for (int k = 1; k < 4; k++) begin
            nxt(k, 0, 7);
            ev(k, 1'b0);
        end
        expw(ACC_TAG_BASE + KIND_TRIPLE, enc(3, 1'b1));
        $display("test triple done");
        // Exact 16 and -128 steps sit on the pair boundaries; then a jump forces two-back.
        for (int k = 4; k < 9; k++) begin
            nxt(k, k == 7 ? 200 : (k < 6 ? 20 : 0), k == 7 ? 50 : (k < 6 ? 80 : 3));
            if (k == 4) s[4][15:0] = s[3][15:0] + 16'h0010;
            if (k == 5) s[5][15:0] = s[4][15:0] - 16'h0080;
            ev(k, 1'b0);
            if (k == 6) expw(ACC_TAG_BASE + KIND_PAIR, enc(6, 1'b0));
            if (k == 6) chk(53'(i_host_model.last), 53'(s[5]), "decoded");
        end
        expw(ACC_TAG_BASE + KIND_NC_T2, s[6]);
        $display("test pair done");
        nxt(9, 0, 1000);
        ev(9, 1'b1);
        expw(CFG_TAG, 48'h3);
        expw(TS_TAG, 48'(ts));
        expw(ACC_TAG_BASE + KIND_NC_T2, s[7]);
        expw(ACC_TAG_BASE + KIND_NC_T1, s[8]);
        expw(ACC_TAG_BASE + KIND_NC, s[9]);
        $display("test flush done");
        bus(1'b1, REG_CTRL, 32'h1);
        for (int k = 10; k < 12; k++) begin
            nxt(k, 0, 1000);
            ev(k, 1'b0);
            if (k == 10) expw(CFG_TAG, 48'h1);
            if (k == 10) expw(TS_TAG, 48'(ts));
            expw(ACC_TAG_BASE + KIND_NC, s[k]);
        end
        bus(1'b0, 4'h2, 32'h0);
        chk(53'(rd), 53'h0, "unmapped read");
        chk(53'(i_host_model.q.size()), 53'h0, "leftover words");
        bus(1'b1, REG_INIT, 32'h1);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(53'(rd), 53'h0, "status");
        $display("test runtime off done");
        test_done();
    end
endmodule // tb
